//--- rtl/prs_pkg.sv
// package: types and constants for the pid regulator limit supervisor
package prs_pkg;

  // timing
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned MS_TIME_US      = 1000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000000 * MS_TIME_US;
  localparam logic [6:0]  DSEC_MS         = 7'h64;   // 100 ms per 0.1 s step

  // scaling (percent in 0.1 % units, frequency in 0.01 Hz units)
  localparam logic signed [15:0] PCT_FULL   = 16'sh03e8;  // 100.0 %
  localparam logic signed [15:0] PCT_NFULL  = -16'sh03e8; // -100.0 %
  localparam logic [15:0]        KP_DIV     = 16'h0064;   // gain 1.00
  localparam logic [15:0]        F_LOW_PT   = 16'h01f4;   // 5.00 Hz
  localparam logic [15:0]        F_HIGH_PT  = 16'h03e8;   // 10.00 Hz
  localparam logic [15:0]        F_SPAN     = 16'h01f4;   // 5.00 Hz
  localparam int unsigned        KI_SHIFT   = 8;

  // control word digit positions (one hex nibble per decimal digit)
  localparam int unsigned CW_FREEZE   = 0;
  localparam int unsigned CW_REVERSE  = 4;
  localparam int unsigned CW_A_BASIS  = 8;
  localparam int unsigned CW_A_BUFFER = 12;

  // reset values
  localparam logic [15:0] CW_RESET   = 16'h0001;
  localparam logic [7:0]  FAULT_CODE = 8'h2a;  // arbitrary display code

  typedef enum logic [1:0] {
    SEQ_ONCE_STOP = 2'b00,
    SEQ_ONCE_HOLD = 2'b01,
    SEQ_CYCLIC    = 2'b10
  } prs_seq_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } prs_seq_state_type;

  // parameter store contents
  typedef struct packed {
    logic signed [15:0] regulator_output_upper_limit;  // 0.1 %
    logic signed [15:0] regulator_output_lower_limit;  // 0.1 %
    logic [15:0]        feedback_loss_threshold;       // 0.1 %
    logic [15:0]        feedback_loss_duration;        // 0.1 s
    logic [15:0]        regulator_control_word;
    logic [15:0]        low_speed_prop_gain;           // 0.01
    logic [15:0]        high_speed_prop_gain;          // 0.01
    logic [15:0]        integral_gain;                 // per sample, /65536
    logic [13:0]        regulator_sample_period;       // 1 ms units
    logic [15:0]        deviation_deadband;            // 0.1 %
    logic [15:0]        command_ramp_time;             // 0.1 s
    logic signed [15:0] regulator_reference;           // 0.1 %
    logic [15:0]        max_output_frequency;          // 0.01 Hz
    logic [15:0]        max_output_voltage;            // 0.1 V
    logic               voltage_mode;
    logic [15:0]        ramp_time_set_four;            // 0.1 s
    prs_seq_mode_type   sequencer_run_mode;
  } prs_cfg_type;

  typedef struct packed {
    logic signed [15:0] val;
    logic [31:0]        acc;
  } prs_ramp_type;

endpackage : prs_pkg

//--- rtl/prs_supervisor.sv
// module: pid regulator output stage, feedback-loss supervision, sequencer
// Behaviour
// [R1] Output is clamped with -100.0 % <= lower <= upper <= 100.0 %; a lower limit above 100.0 % is left uncapped.
// [R2] 100.0 % scales to max output frequency, or max voltage in voltage mode.
// [R3] Feedback at or below threshold longer than duration sets the fault.
// [R4] Feedback above threshold in time avoids fault and restarts timing.
// [R5] Threshold spans 0.0..100.0 %, duration 0.0..3600.0 s in 0.1 s steps.
// [R6] Four 0/1 digits, default 0x0001; ones digit 1 freezes at a limit.
// [R7] Tens digit: output follows (0) or opposes (1) the main direction.
// [R8] Hundreds digit: limit basis max frequency (0) or main reference A (1).
// [R9] Thousands digit 1 ramps reference A with ramp time set four; 0 not; the ramp steps at most one lsb per ms.
// [R10] Gain is low gain <= 5.00 Hz, high gain >= 10.00 Hz, linear between.
// [R11] Mode 0 stops after one cycle and restarts only on a new run command.
// [R12] Mode 1 keeps last section frequency and direction after a cycle.
// [R13] Mode 2 starts the next cycle after each cycle until a stop command.
// [R14] The regulator runs once per sample period of 0.001..10.000 s.
// [R15] Regulation pauses while the absolute deviation is within deadband.
// [R16] The fault latches until fault reset and forces the output to zero.
// [R17] The command ramps at the command ramp time; zero applies at once; steps are at most 0.1 % per ms, so 100.0 % takes at least 1.0 s.
`timescale 1ns/1ns
module prs_supervisor
  import prs_pkg::*;
#(
  parameter int unsigned MS_COUNT = MS_CYCLES
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // parameter store
  input  wire prs_cfg_type        cfg_i,
  // process values
  input  wire logic signed [15:0] feedback_i,
  input  wire logic [15:0]        main_ref_a_i,
  input  wire logic [15:0]        out_freq_i,
  input  wire logic               fault_reset_i,
  // sequencer commands
  input  wire logic               run_cmd_i,
  input  wire logic               stop_cmd_i,
  input  wire logic               cycle_done_i,
  // regulator results
  output logic signed [15:0]      reg_pct_o,
  output logic signed [15:0]      reg_output_o,
  output logic [15:0]             buffered_ref_a_o,
  output logic                    sample_strobe_o,
  // supervision
  output logic                    feedback_lost_o,
  output logic [7:0]              feedback_lost_fault_code_o,
  // sequencer status
  output logic                    seq_running_o,
  output logic                    seq_hold_o,
  output logic                    seq_restart_o
);

  typedef struct packed {
    logic [31:0]        ms_cnt;
    logic [6:0]         dsec_cnt;
    logic [13:0]        samp_cnt;
    logic [15:0]        loss_cnt;
    logic               fault;
    prs_ramp_type       cmd;
    prs_ramp_type       ref_a;
    logic signed [31:0] integ;
    logic               at_limit;
    logic signed [15:0] pct;
    logic signed [15:0] out;
    logic               strobe;
    prs_seq_state_type  seq;
    logic               restart;
    logic [7:0]         code;
    logic               running;
    logic               hold;
  } prs_state_type;

  prs_state_type st;
  prs_state_type next_st;

  // at most one lsb step per millisecond towards target, paced by full scale / time
  function automatic prs_ramp_type ramp(input prs_ramp_type r,
                                        input logic signed [15:0] tgt,
                                        input logic [15:0] fs,
                                        input logic [15:0] t_dsec,
                                        input logic tick);
    prs_ramp_type n;
    logic [31:0]  lim;
    n   = r;
    lim = 32'(t_dsec) * 32'(DSEC_MS);
    if (t_dsec == 16'h0000) begin
      n.val = tgt;
      n.acc = 32'h0;
    end else if (r.val == tgt) begin
      n.acc = 32'h0;
    end else if (tick) begin
      n.acc = r.acc + 32'(fs);
      if (n.acc >= lim) begin
        n.acc = n.acc - lim;
        n.val = (tgt > r.val) ? r.val + 16'sh0001 : r.val - 16'sh0001;
      end
    end
    return n;
  endfunction : ramp

  // gain from output frequency
  function automatic logic [15:0] gain_at(input logic [15:0] f,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic signed [31:0] d;
    d = 32'sh0;
    if (f <= F_LOW_PT) begin
      gain_at = lo;
    end else if (f >= F_HIGH_PT) begin
      gain_at = hi;
    end else begin
      d = ((32'(signed'({1'b0, hi})) - 32'(signed'({1'b0, lo})))
           * 32'(signed'({1'b0, f - F_LOW_PT})))
          / 32'(signed'({1'b0, F_SPAN}));
      gain_at = 16'(32'(signed'({1'b0, lo})) + d);
    end
  endfunction : gain_at

  // one decimal digit of the control word, held as a hex nibble
  function automatic logic cw_digit(input logic [15:0] w,
                                    input int unsigned pos);
    return w[pos];
  endfunction : cw_digit

  logic               ms_tick;
  logic               dsec_tick;
  logic               sample;
  logic signed [15:0] up_lim;
  logic signed [15:0] lo_lim;
  logic signed [16:0] err;
  logic [16:0]        abs_err;
  logic [15:0]        kp;
  logic signed [31:0] p_term;
  logic signed [31:0] i_next;
  logic signed [31:0] sum;
  logic signed [15:0] clamped;
  logic signed [15:0] signed_pct;
  logic [15:0]        basis;
  logic signed [31:0] scaled;
  logic               freeze;
  logic               regulate;
  logic               fb_low;
  logic               loss_set;
  logic               cw_freeze;
  logic               cw_reverse;
  logic               cw_basis;
  logic               cw_buffer;

  // time base, loss supervision, regulator and sequencer
  always_comb begin
    next_st         = st;
    next_st.strobe  = 1'b0;
    next_st.restart = 1'b0;
    ms_tick         = (st.ms_cnt == 32'(MS_COUNT - 1));
    next_st.ms_cnt  = ms_tick ? 32'h0 : st.ms_cnt + 32'h1;
    dsec_tick       = ms_tick && (st.dsec_cnt == DSEC_MS - 7'h01);
    if (ms_tick) begin
      next_st.dsec_cnt = dsec_tick ? 7'h00 : st.dsec_cnt + 7'h01;
    end
    // sample period in whole milliseconds, zero read as one
    sample = 1'b0;
    if (ms_tick) begin
      if (st.samp_cnt + 14'h0001 >= cfg_i.regulator_sample_period) begin
        sample           = 1'b1; // R14
        next_st.samp_cnt = 14'h0000;
      end else begin
        next_st.samp_cnt = st.samp_cnt + 14'h0001;
      end
    end
    next_st.strobe = sample;

    // loss timing in 0.1 s steps
    loss_set = 1'b0;
    fb_low   = feedback_i <= signed'({1'b0,
               cfg_i.feedback_loss_threshold[14:0]});
    if (!fb_low) begin
      next_st.loss_cnt = 16'h0000; // R4
    end else if (dsec_tick) begin
      if (st.loss_cnt >= cfg_i.feedback_loss_duration) begin
        loss_set = 1'b1; // R3 R5
      end else begin
        next_st.loss_cnt = st.loss_cnt + 16'h0001; // R5
      end
    end
    // a loss event in the same cycle wins over a fault reset
    if (loss_set) begin
      next_st.fault = 1'b1; // R3
    end else if (fault_reset_i) begin
      next_st.fault = 1'b0; // R16
    end

    // control word digits
    cw_freeze  = cw_digit(cfg_i.regulator_control_word, CW_FREEZE); // R6
    cw_reverse = cw_digit(cfg_i.regulator_control_word, CW_REVERSE); // R7
    cw_basis   = cw_digit(cfg_i.regulator_control_word, CW_A_BASIS); // R8
    cw_buffer  = cw_digit(cfg_i.regulator_control_word, CW_A_BUFFER); // R9

    // command and reference a ramps
    next_st.cmd = ramp(st.cmd, cfg_i.regulator_reference, 16'(PCT_FULL),
                       cfg_i.command_ramp_time, ms_tick); // R17
    if (cw_buffer) begin
      next_st.ref_a = ramp(st.ref_a, signed'(main_ref_a_i),
                           cfg_i.max_output_frequency,
                           cfg_i.ramp_time_set_four, ms_tick); // R9
    end else begin
      next_st.ref_a.val = signed'(main_ref_a_i); // R9
      next_st.ref_a.acc = 32'h0;
    end

    // lower limit floored at -100.0 %, upper capped at 100.0 % then raised to the lower
    up_lim = cfg_i.regulator_output_upper_limit;
    lo_lim = cfg_i.regulator_output_lower_limit;
    if (lo_lim < PCT_NFULL) lo_lim = PCT_NFULL; // R1
    if (up_lim > PCT_FULL) up_lim = PCT_FULL; // R1
    if (up_lim < lo_lim) up_lim = lo_lim; // R1

    // regulator arithmetic
    err     = 17'(st.cmd.val) - 17'(feedback_i);
    abs_err = err[16] ? 17'(-err) : 17'(err);
    kp      = gain_at(out_freq_i, cfg_i.low_speed_prop_gain,
                      cfg_i.high_speed_prop_gain); // R10
    p_term  = (32'(err) * 32'(signed'({1'b0, kp})))
              / 32'(signed'({1'b0, KP_DIV}));
    freeze  = cw_freeze && st.at_limit;
    i_next  = freeze ? st.integ
              : st.integ + ((32'(err) * 32'(signed'({1'b0,
                cfg_i.integral_gain}))) >>> KI_SHIFT); // R6
    sum     = p_term + (i_next >>> KI_SHIFT);
    if (sum > 32'(up_lim)) begin
      clamped = up_lim; // R1
    end else if (sum < 32'(lo_lim)) begin
      clamped = lo_lim; // R1
    end else begin
      clamped = 16'(sum);
    end
    // regulate only on a sample outside the deadband
    regulate = sample
               && (abs_err > 17'({1'b0, cfg_i.deviation_deadband})); // R15
    if (st.fault) begin
      next_st.pct      = 16'sh0000; // R16
      next_st.integ    = 32'sh0;
      next_st.at_limit = 1'b0;
    end else if (regulate) begin
      next_st.pct      = clamped; // R14
      next_st.at_limit = (sum >= 32'(up_lim)) || (sum <= 32'(lo_lim));
      if (!next_st.at_limit || !cw_freeze) begin
        next_st.integ = i_next; // R6
      end
    end

    // direction and scaling
    signed_pct = cw_reverse ? -st.pct
                 : st.pct; // R7
    if (cfg_i.voltage_mode) begin
      basis = cfg_i.max_output_voltage; // R2
    end else if (cw_basis) begin
      basis = st.ref_a.val[15] ? 16'h0000 : 16'(st.ref_a.val); // R8
    end else begin
      basis = cfg_i.max_output_frequency; // R2 R8
    end
    scaled      = (32'(signed_pct) * 32'(signed'({1'b0, basis})))
                  / 32'(PCT_FULL); // R2
    next_st.out = st.fault ? 16'sh0000 : 16'(scaled); // R16

    // sequencer run modes
    case (st.seq)
      ST_IDLE: begin
        if (run_cmd_i && !stop_cmd_i) next_st.seq = ST_RUN; // R11
      end
      ST_RUN: begin
        if (stop_cmd_i) begin
          next_st.seq = ST_IDLE;
        end else if (cycle_done_i) begin
          case (cfg_i.sequencer_run_mode)
            SEQ_ONCE_HOLD: next_st.seq = ST_HOLD; // R12
            SEQ_CYCLIC:    next_st.restart = 1'b1; // R13
            default:       next_st.seq = ST_IDLE; // R11
          endcase
        end
      end
      ST_HOLD: begin
        if (stop_cmd_i) next_st.seq = ST_IDLE; // R12
      end
      default: next_st.seq = ST_IDLE;
    endcase

    // decoded status kept in flip-flops so outputs need no logic
    next_st.code    = next_st.fault ? FAULT_CODE : 8'h00; // R3
    next_st.running = (next_st.seq == ST_RUN);
    next_st.hold    = (next_st.seq == ST_HOLD);
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_pct_o                  = st.pct;
  assign reg_output_o               = st.out;
  assign buffered_ref_a_o           = 16'(st.ref_a.val);
  assign sample_strobe_o            = st.strobe;
  assign feedback_lost_o            = st.fault; // R3
  assign feedback_lost_fault_code_o = st.code; // R3
  assign seq_running_o              = st.running;
  assign seq_hold_o                 = st.hold;
  assign seq_restart_o              = st.restart;

endmodule : prs_supervisor

//--- sim/prs_plant.sv
// model of the drive power stage and the process feedback sensor
`timescale 1ns/1ns
module prs_plant (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // process state set by the bench
  input  wire logic signed [15:0] level_i,
  input  wire logic               offline_i,
  input  wire logic [15:0]        speed_i,
  // sensed values
  output logic signed [15:0]      feedback_o,
  output logic [15:0]             out_freq_o
);
  // a broken sensor line reads zero, it never holds the last value
  assign feedback_o = offline_i ? 16'sh0000 : level_i;
  // the power stage reports its speed one cycle late
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) out_freq_o <= 16'h0000;
    else out_freq_o <= speed_i;
  end
endmodule : prs_plant

//--- sim/prs_supervisor_chk.sv
// checker: port-level properties of the regulator supervisor
`timescale 1ns/1ns
module prs_supervisor_chk
  import prs_pkg::*;
#(
  parameter int unsigned MS_COUNT = MS_CYCLES
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire prs_cfg_type        cfg_i,
  input wire logic signed [15:0] feedback_i,
  input wire logic               fault_reset_i,
  input wire logic               run_cmd_i,
  input wire logic               stop_cmd_i,
  input wire logic               cycle_done_i,
  input wire logic signed [15:0] reg_pct_o,
  input wire logic signed [15:0] reg_output_o,
  input wire logic               sample_strobe_o,
  input wire logic               feedback_lost_o,
  input wire logic [7:0]         feedback_lost_fault_code_o,
  input wire logic               seq_running_o,
  input wire logic               seq_hold_o,
  input wire logic               seq_restart_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // threshold seen as a signed level
  logic signed [15:0] thr;
  logic               dn;
  assign thr = $signed(cfg_i.feedback_loss_threshold);
  assign dn = seq_running_o && cycle_done_i && !stop_cmd_i;
  strobe_spacing_a: assert property (
    sample_strobe_o |=> !sample_strobe_o [*8]) else $error("strobe spacing");
  code_follow_a: assert property (feedback_lost_fault_code_o ==
    (feedback_lost_o ? FAULT_CODE : 8'h00)) else $error("fault code");
  fault_latch_a: assert property (
    feedback_lost_o && !fault_reset_i |=> feedback_lost_o)
    else $error("fault dropped");
  fault_clear_a: assert property (feedback_lost_o && fault_reset_i &&
    feedback_i > thr |=> !feedback_lost_o) else $error("fault kept");
  no_early_a: assert property (
    (!feedback_lost_o && feedback_i > thr) [*2] |=> !feedback_lost_o)
    else $error("fault with good feedback");
  fault_inhibit_a: assert property (feedback_lost_o [*3] |->
    reg_pct_o == 0 && reg_output_o == 0) else $error("output in fault");
  limit_band_a: assert property (sample_strobe_o && !feedback_lost_o &&
    $past(cfg_i, 2) == cfg_i |->
    reg_pct_o <= cfg_i.regulator_output_upper_limit &&
    reg_pct_o >= cfg_i.regulator_output_lower_limit) else $error("limit");
  scale_full_a: assert property (
    sample_strobe_o && reg_pct_o == PCT_FULL && !cfg_i.voltage_mode &&
    !cfg_i.regulator_control_word[CW_A_BASIS] &&
    !cfg_i.regulator_control_word[CW_REVERSE] |=>
    $unsigned(reg_output_o) == $past(cfg_i.max_output_frequency))
    else $error("full scale");
  seq_stop_a: assert property (dn &&
    cfg_i.sequencer_run_mode == SEQ_ONCE_STOP |=> !seq_running_o)
    else $error("no stop");
  seq_hold_a: assert property (dn &&
    cfg_i.sequencer_run_mode == SEQ_ONCE_HOLD |=> seq_hold_o)
    else $error("no hold");
  seq_cycle_a: assert property (dn && cfg_i.sequencer_run_mode ==
    SEQ_CYCLIC |=> seq_restart_o && seq_running_o) else $error("no cycle");
  seq_start_a: assert property (!seq_running_o && !seq_hold_o &&
    run_cmd_i && !stop_cmd_i |=> seq_running_o) else $error("no start");
  // main scenarios reached
  cover property ($rose(feedback_lost_o));
  cover property (seq_restart_o);
  cover property ($rose(seq_hold_o));
endmodule : prs_supervisor_chk

//--- sim/testbench.sv
// self-checking bench for the regulator supervisor
`timescale 1ns/1ns
module testbench;
  import prs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, fault_reset_i = 1'b0;
  logic run_cmd_i = 1'b0, stop_cmd_i = 1'b0, cycle_done_i = 1'b0;
  logic offline = 1'b0;
  logic signed [15:0] level = 16'sh01f4, feedback_i;
  logic [15:0] main_ref_a_i = 16'h0000, speed = 16'h0000, out_freq_i;
  logic signed [15:0] reg_pct_o, reg_output_o;
  logic [15:0] buffered_ref_a_o;
  logic sample_strobe_o, feedback_lost_o, seq_running_o, seq_hold_o;
  logic seq_restart_o;
  logic [7:0] feedback_lost_fault_code_o;
  prs_cfg_type cfg_i;
  int n_mismatch = 0, checked = 0;
  `define CHK(n, e, g) chk(n, e, g)
  prs_supervisor #(.MS_COUNT(10)) i_prs_supervisor (.clk_i(clk_i),
    .rst_i(rst_i), .cfg_i(cfg_i), .feedback_i(feedback_i),
    .main_ref_a_i(main_ref_a_i), .out_freq_i(out_freq_i),
    .fault_reset_i(fault_reset_i), .run_cmd_i(run_cmd_i),
    .stop_cmd_i(stop_cmd_i), .cycle_done_i(cycle_done_i),
    .reg_pct_o(reg_pct_o), .reg_output_o(reg_output_o),
    .buffered_ref_a_o(buffered_ref_a_o), .sample_strobe_o(sample_strobe_o),
    .feedback_lost_o(feedback_lost_o),
    .feedback_lost_fault_code_o(feedback_lost_fault_code_o),
    .seq_running_o(seq_running_o), .seq_hold_o(seq_hold_o),
    .seq_restart_o(seq_restart_o));
  prs_plant i_prs_plant (.clk_i(clk_i), .rst_i(rst_i), .level_i(level),
    .offline_i(offline), .speed_i(speed), .feedback_o(feedback_i),
    .out_freq_o(out_freq_i));
  // clock source
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  // two samples under steady settings, then scaled output settles
  task automatic settle;
    int k;
    repeat (2) begin
      k = 0;
      do begin
        cyc(1);
        k++;
      end while (!sample_strobe_o && k < 100);
      if (k >= 100) begin
        n_mismatch++;
        test_done();
      end
    end
    cyc(1);
  endtask : settle
  task automatic t_clamp;
    cfg_i.regulator_reference = 16'sh03e8;
    cfg_i.low_speed_prop_gain = 16'h03e8;
    cfg_i.high_speed_prop_gain = 16'h03e8;
    cfg_i.regulator_output_upper_limit = 16'sh012c;
    cfg_i.regulator_output_lower_limit = -16'sh00c8;
    settle();
    `CHK("upper clamp", 300, reg_pct_o);
    `CHK("freq scale", 1500, reg_output_o);
    cfg_i.regulator_control_word = 16'h0011;
    settle();
    `CHK("reverse", -1500, reg_output_o);
    cfg_i.regulator_control_word = 16'h0101;
    main_ref_a_i = 16'h07d0;
    settle();
    `CHK("basis a", 600, reg_output_o);
    cfg_i.regulator_control_word = CW_RESET;
    cfg_i.voltage_mode = 1'b1;
    settle();
    `CHK("volt scale", 1140, reg_output_o);
    cfg_i.voltage_mode = 1'b0;
    cfg_i.regulator_output_upper_limit = PCT_FULL;
    settle();
    `CHK("full scale", 5000, reg_output_o);
  endtask : t_clamp
  task automatic t_gain;
    logic [15:0] sp [3] = '{16'h01f4, 16'h02ee, 16'h03e8};
    int ex [3] = '{50, 100, 150};
    cfg_i.regulator_output_lower_limit = PCT_NFULL;
    cfg_i.regulator_reference = 16'sh0064;
    level = 16'sh0032;
    cfg_i.low_speed_prop_gain = 16'h0064;
    cfg_i.high_speed_prop_gain = 16'h012c;
    for (int i = 0; i < 3; i++) begin
      speed = sp[i];
      settle();
      `CHK("gain", ex[i], reg_pct_o);
    end
    speed = 16'h02ee;
    settle();
    cfg_i.deviation_deadband = 16'h003c;
    speed = 16'h03e8;
    settle();
    `CHK("deadband hold", 100, reg_pct_o);
    cfg_i.deviation_deadband = 16'h0000;
  endtask : t_gain
  task automatic t_buffer;
    cfg_i.regulator_control_word = 16'h1001;
    cfg_i.ramp_time_set_four = 16'h000a;
    main_ref_a_i = 16'h0000;
    cyc(25);
    `CHK("ramped a", 1, buffered_ref_a_o inside {[16'h07cd:16'h07cf]});
    cfg_i.regulator_control_word = CW_RESET;
    cyc(3);
    `CHK("direct a", 0, buffered_ref_a_o);
    cfg_i.command_ramp_time = 16'h0001;
    cfg_i.regulator_reference = 16'sh006e;
    settle();
    `CHK("cmd ramp", 1, reg_pct_o > 150 && reg_pct_o < 180);
    cfg_i.command_ramp_time = 16'h0000;
  endtask : t_buffer
  task automatic t_fault;
    int n;
    cfg_i.feedback_loss_threshold = 16'h0064;
    cfg_i.feedback_loss_duration = 16'h0002;
    level = 16'sh01f4;
    repeat (4) begin
      offline = 1'b1;
      cyc(900);
      offline = 1'b0;
      cyc(5);
      `CHK("short loss", 0, feedback_lost_o);
    end
    offline = 1'b1;
    n = 0;
    while (!feedback_lost_o && n < 3200) begin
      cyc(1);
      n++;
    end
    `CHK("loss time", 1, n > 2000 && n < 3200);
    if (n >= 3200) test_done();
    `CHK("loss code", FAULT_CODE, feedback_lost_fault_code_o);
    cyc(3);
    `CHK("inhibit", 0, reg_pct_o);
    `CHK("inhibit out", 0, reg_output_o);
    offline = 1'b0;
    cyc(20);
    `CHK("latched", 1, feedback_lost_o);
    fault_reset_i = 1'b1;
    cyc(1);
    fault_reset_i = 1'b0;
    cyc(1);
    `CHK("cleared", 0, feedback_lost_o);
  endtask : t_fault
  task automatic t_seq;
    for (int m = 0; m < 3; m++) begin
      cfg_i.sequencer_run_mode = prs_seq_mode_type'(m);
      run_cmd_i = 1'b1;
      cyc(1);
      run_cmd_i = 1'b0;
      `CHK("started", 1, seq_running_o);
      cycle_done_i = 1'b1;
      cyc(1);
      cycle_done_i = 1'b0;
      `CHK("after cycle", m == 2, seq_running_o);
      `CHK("hold", m == 1, seq_hold_o);
      `CHK("restart", m == 2, seq_restart_o);
      stop_cmd_i = 1'b1;
      cyc(1);
      stop_cmd_i = 1'b0;
      `CHK("stopped", 0, seq_running_o | seq_hold_o);
    end
  endtask : t_seq
  // reset, then the scenarios in turn
  initial begin
    cfg_i = '0;
    cfg_i.regulator_output_upper_limit = PCT_FULL;
    cfg_i.regulator_output_lower_limit = PCT_NFULL;
    cfg_i.regulator_control_word = CW_RESET;
    cfg_i.regulator_sample_period = 14'h0001;
    cfg_i.max_output_frequency = 16'h1388;
    cfg_i.max_output_voltage = 16'h0ed8;
    cfg_i.feedback_loss_duration = 16'h0014;
    cyc(10);
    rst_i = 1'b0;
    cyc(1);
    `CHK("reset lost", 0, feedback_lost_o);
    t_clamp();
    t_gain();
    t_buffer();
    t_fault();
    t_seq();
    test_done();
  end
endmodule : testbench
bind prs_supervisor prs_supervisor_chk #(.MS_COUNT(MS_COUNT))
  i_prs_supervisor_chk (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i),
  .feedback_i(feedback_i), .fault_reset_i(fault_reset_i),
  .run_cmd_i(run_cmd_i), .stop_cmd_i(stop_cmd_i),
  .cycle_done_i(cycle_done_i), .reg_pct_o(reg_pct_o),
  .reg_output_o(reg_output_o), .sample_strobe_o(sample_strobe_o),
  .feedback_lost_o(feedback_lost_o),
  .feedback_lost_fault_code_o(feedback_lost_fault_code_o),
  .seq_running_o(seq_running_o), .seq_hold_o(seq_hold_o),
  .seq_restart_o(seq_restart_o));
